// ===== strobe_bridge.sv
// bus buffering, address latch, decoder and rate generator top
`timescale 1ns/1ps
`include "strobe_bridge_defines.svh"
module strobe_bridge
    import strobe_bridge_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [`ADDR_W-1:0] ctl_addr, // controller address
    input wire logic ctl_ale, // address latch strobe
    input wire logic ctl_rd, // read access level
    input wire logic [`CTRL_W-1:0] ctl_ctrl, // controller control lines
    input wire logic [`DATA_W-1:0] ctl_data_i, // controller data in
    output logic [`DATA_W-1:0] ctl_data_o, // data toward controller
    output logic ctl_data_oe_n, // low when driving controller
    input wire logic [`DATA_W-1:0] brd_data_i, // board data in
    output logic [`DATA_W-1:0] brd_data_o, // data toward board
    output logic brd_data_oe_n, // low when driving board
    output logic [`ADDR_W-1:0] brd_addr, // latched address
    output logic [`CTRL_W-1:0] brd_ctrl, // buffered control lines
    output logic sel_board, // access hits this board
    output logic sel_acq, // access hits acquisition boards
    input wire logic in_clk, // jumper clock input
    input wire logic div_load, // load strobe for divider
    output logic clk_out // square wave clock
);
    // access timing, counted from the edge that latches the address:
    //   that edge: address captured into the latch
    //   next edge: decode flags registered from the latched value
    //   same edge: enables registered, if the strobe has dropped
    //   afterwards: enables track the read level one edge behind
    // the strobe forces both enables off, so a new address cycle
    // never overlaps a data phase still in flight
    // every port leaves a flop; nothing reaches a pin through logic

    // address latch
    logic [`ADDR_W-1:0] addr_q; // latched address
    logic [`ADDR_W-1:0] addr_d; // next latch value
    // control buffer
    logic [`CTRL_W-1:0] ctrl_q; // buffered control lines
    logic [`CTRL_W-1:0] ctrl_d; // next control value
    // data buffers toward each side
    logic [`DATA_W-1:0] cdo_q; // data toward controller
    logic [`DATA_W-1:0] cdo_d; // next controller data
    logic [`DATA_W-1:0] bdo_q; // data toward board
    logic [`DATA_W-1:0] bdo_d; // next board data
    // buffer enables, low while driving
    logic coe_n_q; // controller side enable
    logic coe_n_d; // next controller enable
    logic boe_n_q; // board side enable
    logic boe_n_d; // next board enable
    // registered decode flags
    logic sb_q; // hit on this board
    logic sb_d; // next board hit
    logic sa_q; // hit on acquisition boards
    logic sa_d; // next acquisition hit
    // square wave retimed at the top
    logic clk_q; // output clock flop
    logic clk_d; // next output clock
    // combinational decode results and the divider square wave
    target_t tgt; // decoded target
    logic hit; // latched address decodes
    logic drive_ok; // data phase of a hit
    logic sq; // divider square wave

    // address latch: reloads on every edge while the strobe is high, then holds
    // the captured address so decode never sees the data phase lines
    always_comb begin
        addr_d = addr_q; // hold through the data phase
        if (ctl_ale) begin
            addr_d = ctl_addr; // capture
        end
    end

    // address latch register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    // partial decode of the latched upper address bits; lower bits
    // take no part, so each target answers a whole address window
    always_comb begin
        case (addr_q[`DEC_HI:`DEC_LO])
            `BOARD_BASE: begin
                tgt = SEL_BOARD;
            end
            `ACQ_BASE: begin
                tgt = SEL_ACQ;
            end
            default: begin
                tgt = SEL_NONE;
            end
        endcase
        hit = (tgt != SEL_NONE);
        drive_ok = hit && !ctl_ale; // strobe forces buffers off
        sb_d = (tgt == SEL_BOARD);
        sa_d = (tgt == SEL_ACQ);
    end

    // decode flag registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_q <= 1'b0;
            sa_q <= 1'b0;
        end else begin
            sb_q <= sb_d;
            sa_q <= sa_d;
        end
    end

    // one-way control buffer, one edge of lag; control lines
    // carry no enable of their own and always pass
    always_comb begin
        ctrl_d = ctl_ctrl;
    end

    // control buffer register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // direction steering: reads face the controller, writes the board;
    // a miss leaves both sides undriven so another board may answer,
    // and at most one enable is ever low
    always_comb begin
        coe_n_d = 1'b1; // off on a miss
        boe_n_d = 1'b1; // off on a miss
        if (drive_ok) begin
            coe_n_d = ~ctl_rd; // read drives controller
            boe_n_d = ctl_rd; // write drives board
        end
    end

    // buffer enable registers, both off in reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            coe_n_q <= 1'b1;
            boe_n_q <= 1'b1;
        end else begin
            coe_n_q <= coe_n_d;
            boe_n_q <= boe_n_d;
        end
    end

    // data buffers in both directions; data is copied every edge and
    // only the enables decide which side sees it
    always_comb begin
        cdo_d = brd_data_i; // board toward controller
        bdo_d = ctl_data_i; // controller toward board
    end

    // data buffer registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cdo_q <= '0;
            bdo_q <= '0;
        end else begin
            cdo_q <= cdo_d;
            bdo_q <= bdo_d;
        end
    end

    // divider reload value carried on the controller data bus;
    // a load strobe restarts the count, a zero load runs at the
    // shortest ratio, and reset leaves the power-on ratio in place
    rate_divider u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_clk(in_clk),
        .load(div_load),
        .load_val(ctl_data_i),
        .sq_out(sq)
    );

    // square wave retimed so the output leaves a top level flop;
    // costs one edge of lag, duty cycle unchanged
    always_comb begin
        clk_d = sq;
    end

    // output clock register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= clk_d;
        end
    end

    // ports straight from the registers above
    assign brd_addr = addr_q;
    assign brd_ctrl = ctrl_q;
    assign ctl_data_o = cdo_q;
    assign brd_data_o = bdo_q;
    assign ctl_data_oe_n = coe_n_q;
    assign brd_data_oe_n = boe_n_q;
    assign sel_board = sb_q;
    assign sel_acq = sa_q;
    assign clk_out = clk_q;
endmodule : strobe_bridge

// ===== strobe_bridge_defines.svh
// constants for the strobe board bus bridge and clock divider
`ifndef STROBE_BRIDGE_DEFINES_SVH
`define STROBE_BRIDGE_DEFINES_SVH
`define ADDR_W 20
`define DATA_W 16
`define CTRL_W 8
`define DIV_W 16
`define DEC_HI 19
`define DEC_LO 15
`define BOARD_BASE 5'h1E
`define ACQ_BASE 5'h1F
`define DIV_RESET 16'h0013
`define DIV_MIN 16'h0001
`endif

// ===== strobe_bridge_pkg.sv
// types shared by the strobe board bus bridge
package strobe_bridge_pkg;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_BOARD,
        SEL_ACQ
    } target_t;
endpackage : strobe_bridge_pkg

// ===== rate_divider.sv
// programmable clock-rate divider with divide-by-two output
`timescale 1ns/1ps
`include "strobe_bridge_defines.svh"
module rate_divider (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic in_clk, // jumper clock input, synchronous
    input wire logic load, // one-cycle load strobe
    input wire logic [`DIV_W-1:0] load_val, // reload value
    output logic sq_out // square wave output
);
    logic [`DIV_W-1:0] reload_q, reload_d;
    logic [`DIV_W-1:0] cnt_q, cnt_d;
    logic sq_q, sq_d;
    logic in_q;
    logic in_rise;
    logic [`DIV_W-1:0] load_eff;

    assign in_rise = in_clk & ~in_q;
    // zero load would give a ratio of two, below the floor
    assign load_eff = (load_val == '0) ? `DIV_MIN : load_val;

    // down counter reload, terminal count toggles output
    always_comb begin
        reload_d = load ? load_eff : reload_q;
        cnt_d = cnt_q;
        sq_d = sq_q;
        if (load) begin
            cnt_d = load_eff;
        end else if (in_rise) begin
            if (cnt_q == '0) begin
                cnt_d = reload_q; // ratio 2*(n+1): 4..2^17
                sq_d = ~sq_q; // even duty cycle
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= `DIV_RESET;
            cnt_q <= `DIV_RESET;
            sq_q <= 1'b0;
            in_q <= 1'b0;
        end else begin
            reload_q <= reload_d;
            cnt_q <= cnt_d;
            sq_q <= sq_d;
            in_q <= in_clk;
        end
    end

    assign sq_out = sq_q;
endmodule : rate_divider

// ===== ctl_model.sv
// controller bus model: address cycles and divider load
`timescale 1ns/1ps
`include "strobe_bridge_defines.svh"
module ctl_model (
    input wire logic sys_clk, // clock
    output logic [`ADDR_W-1:0] ctl_addr, // address
    output logic ctl_ale, // latch strobe
    output logic ctl_rd, // read level
    output logic [`DATA_W-1:0] ctl_data_i, // data
    output logic div_load // load strobe
);
    initial {ctl_addr, ctl_ale, ctl_rd, ctl_data_i, div_load} = '0;
    // latch cycle, then data phase; released lines show inverse
    task acc(input logic [19:0] a, input logic r, input logic [15:0] d);
        @(posedge sys_clk) #1;
        {ctl_addr, ctl_ale, ctl_rd} = {a, 1'b1, r};
        ctl_data_i = r ? ~ctl_data_i : d;
        @(posedge sys_clk) #1;
        {ctl_addr, ctl_ale} = {~a, 1'b0};
    endtask : acc
    // one-cycle divider load
    task ld(input logic [15:0] v);
        @(posedge sys_clk) #1;
        {ctl_data_i, div_load} = {v, 1'b1};
        @(posedge sys_clk) #1;
        div_load = 1'b0;
    endtask : ld
endmodule : ctl_model

// ===== strobe_bridge_sva.sv
// port assertions for the strobe board bridge
`timescale 1ns/1ps
`include "strobe_bridge_defines.svh"
module strobe_bridge_sva (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic ctl_ale, // address latch strobe
    input wire logic ctl_rd, // read level
    input wire logic [`ADDR_W-1:0] ctl_addr, // controller address
    input wire logic [`ADDR_W-1:0] brd_addr, // latched address
    input wire logic [`CTRL_W-1:0] ctl_ctrl, // controller control lines
    input wire logic [`CTRL_W-1:0] brd_ctrl, // buffered control lines
    input wire logic [`DATA_W-1:0] ctl_data_i, // controller data
    input wire logic [`DATA_W-1:0] ctl_data_o, // data to controller
    input wire logic [`DATA_W-1:0] brd_data_i, // board data
    input wire logic [`DATA_W-1:0] brd_data_o, // data to board
    input wire logic ctl_data_oe_n, // controller side enable
    input wire logic brd_data_oe_n, // board side enable
    input wire logic sel_board, // board hit
    input wire logic sel_acq // acquisition hit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idle; !sel_board && !sel_acq; endsequence
    sequence s_drive; !(ctl_data_oe_n && brd_data_oe_n); endsequence
    a_addr_latch: assert property (ctl_ale |=>
        brd_addr == $past(ctl_addr)) else $error("latch wrong");
    a_addr_hold: assert property (!ctl_ale |=>
        $stable(brd_addr)) else $error("latch moved");
    a_sel_dec: assert property ({sel_acq, sel_board} ==
        {$past(brd_addr[`DEC_HI:`DEC_LO]) == `ACQ_BASE,
        $past(brd_addr[`DEC_HI:`DEC_LO]) == `BOARD_BASE})
        else $error("decode");
    a_ctrl_pass: assert property ($past(rst_n) |->
        brd_ctrl == $past(ctl_ctrl)) else $error("ctrl buffer");
    a_data_pass: assert property ($past(rst_n) |->
        brd_data_o == $past(ctl_data_i) &&
        ctl_data_o == $past(brd_data_i)) else $error("data buffer");
    a_miss_off: assert property (s_idle[*2] |->
        ctl_data_oe_n && brd_data_oe_n) else $error("miss drives");
    a_ale_off: assert property (ctl_ale |=>
        ctl_data_oe_n && brd_data_oe_n) else $error("ale drives");
    a_dir_rd: assert property (s_drive |->
        brd_data_oe_n == $past(ctl_rd)) else $error("direction");
    a_one_dir: assert property (ctl_data_oe_n ||
        brd_data_oe_n) else $error("both drive");
endmodule : strobe_bridge_sva
bind strobe_bridge strobe_bridge_sva u_sva (.sys_clk, .rst_n, .ctl_ale,
    .ctl_rd, .ctl_addr, .brd_addr, .ctl_ctrl, .brd_ctrl, .ctl_data_i,
    .ctl_data_o, .brd_data_i, .brd_data_o, .ctl_data_oe_n,
    .brd_data_oe_n, .sel_board, .sel_acq);

// ===== strobe_bridge_tb.sv
// self-checking bench for the strobe board bridge
`timescale 1ns/1ps
`include "strobe_bridge_defines.svh"
module strobe_bridge_tb;
    logic sys_clk = 0, rst_n = 0, in_clk = 0, ctl_ale, ctl_rd, div_load;
    logic clk_out, sel_board, sel_acq, ctl_data_oe_n, brd_data_oe_n;
    logic [`ADDR_W-1:0] ctl_addr, brd_addr;
    logic [`CTRL_W-1:0] ctl_ctrl = 8'hA5, brd_ctrl;
    logic [`DATA_W-1:0] ctl_data_i, ctl_data_o, brd_data_o;
    logic [`DATA_W-1:0] brd_data_i = 16'h3C5A;
    int n_fail = 0, checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    // jumper clock: one rising edge per two cycles
    always @(posedge sys_clk) #1 in_clk = ~in_clk;
    ctl_model u_ctl (.sys_clk, .ctl_addr, .ctl_ale, .ctl_rd, .ctl_data_i,
        .div_load);
    strobe_bridge u_dut (.sys_clk, .rst_n, .ctl_addr, .ctl_ale, .ctl_rd,
        .ctl_ctrl, .ctl_data_i, .ctl_data_o, .ctl_data_oe_n, .brd_data_i,
        .brd_data_o, .brd_data_oe_n, .brd_addr, .brd_ctrl, .sel_board,
        .sel_acq, .in_clk, .div_load, .clk_out);
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // access, settle, then judge latch, decode, direction, buffers
    task acc_chk(input logic [19:0] a, input logic r, input logic [1:0] h);
        @(posedge sys_clk) #1 ctl_ctrl = ~ctl_ctrl; // fresh control pattern
        u_ctl.acc(a, r, a[15:0] ^ 16'h1234);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(brd_addr, a);
        chk({sel_acq, sel_board}, h);
        chk({ctl_data_oe_n, brd_data_oe_n}, h ? {!r, r} : 2'b11);
        chk({ctl_data_o, brd_data_o}, {brd_data_i, ctl_data_i});
        chk(brd_ctrl, ctl_ctrl);
    endtask : acc_chk
    // mid-run reset: enables off, latch, decode and clock cleared
    task t_reset;
        @(posedge sys_clk) #1 rst_n = 0;
        @(posedge sys_clk) #1;
        chk({ctl_data_oe_n, brd_data_oe_n}, 2'b11);
        chk({brd_addr, sel_acq, sel_board, clk_out}, '0);
        rst_n = 1;
    endtask : t_reset
    // clk_out high time and period in cycles
    task per(input int e);
        time t;
        @(posedge clk_out) t = $time;
        @(negedge clk_out) chk(32'(($time - t) / 5), e / 2);
        @(posedge clk_out) chk(32'(($time - t) / 5), e);
    endtask : per
    // ratio of forty loaded as 16'h0013, then the floor of four for a zero load
    task t_div;
        u_ctl.ld(16'h0013);
        per(80);
        u_ctl.ld(16'h0000);
        @(posedge clk_out);
        per(8);
    endtask : t_div
    task t_hits;
        acc_chk(20'hF0000, 1'b1, 2'b01);
        acc_chk(20'hF8000, 1'b0, 2'b10);
    endtask : t_hits
    task t_miss;
        acc_chk(20'hE8000, 1'b1, 2'b00);
        acc_chk(20'h00000, 1'b0, 2'b00);
    endtask : t_miss
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1;
        t_div;
        t_hits;
        t_reset;
        t_miss;
        print_verdict;
    end
    initial begin
        #20000;
        n_fail++;
        print_verdict;
    end
    task print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
endmodule : strobe_bridge_tb
